// ===== vsoc_strobe_ctrl.sv
`timescale 1ns/1ps
`include "vsoc_defines.svh"

// Behaviour
// - Hold column strobe past row end, one clock
// - Early row end gains precharge clock
// - Sample column enable zero at mode load
// - Transfer enable low during shift load
// - Transfer enable high during writes
// - Read: transfer enable follows column strobe
// - Page mode read toggles transfer enable
module vsoc_strobe_ctrl (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic nrst_i,
  // Controller core
  input  wire logic row_active_i,
  input  wire logic access_write_i,
  input  wire logic shift_load_i,
  input  wire logic single_bank_sequencing_i,
  input  wire logic mode_load_i,
  // Pins from processor side
  input  wire logic column_enable_in_n_i,
  input  wire logic column_enable_in_zero_i,
  // Memory strobes and mode bit
  output logic      row_strobe_n_o,
  output logic      column_strobe_n_o,
  output logic      transfer_output_enable_o,
  output logic      extra_mode_o
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1_q;
  logic rst_s1_d;
  logic rst_n_q;
  logic rst_n_d;

  always_comb
  begin
    rst_s1_d = 1'b1;
    rst_n_d  = rst_s1_q;
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= rst_s1_d;
      rst_n_q  <= rst_n_d;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] cen_s1_q;
  logic [1:0] cen_s1_d;
  logic [1:0] cen_s2_q;
  logic [1:0] cen_s2_d;

  always_comb
  begin
    cen_s1_d = {column_enable_in_zero_i, column_enable_in_n_i};
    cen_s2_d = cen_s1_q;
  end

  always_ff @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cen_s1_q <= `VSOC_PIN_IDLE;
      cen_s2_q <= `VSOC_PIN_IDLE;
    end
    else
    begin
      cen_s1_q <= cen_s1_d;
      cen_s2_q <= cen_s2_d;
    end
  end

  // ----------------------------------------
  // Strobe sequencing
  // ----------------------------------------
  vsoc_pkg::vsoc_state_t state_q;
  vsoc_pkg::vsoc_state_t state_d;
  logic                  row_n_d;
  logic                  col_n_d;
  logic                  xfer_d;
  logic                  mode_d;
  logic                  mode_q;
  logic                  write_q;
  logic                  write_d;

  always_comb
  begin
    state_d = state_q;
    row_n_d = `VSOC_STROBE_IDLE;
    col_n_d = `VSOC_STROBE_IDLE;
    case (state_q)
      vsoc_pkg::VSOC_ST_IDLE:
      begin
        if (row_active_i)
        begin
          state_d = vsoc_pkg::VSOC_ST_ROW;
          row_n_d = `VSOC_STROBE_ACT;
        end
      end
      vsoc_pkg::VSOC_ST_ROW:
      begin
        if (row_active_i)
        begin
          row_n_d = `VSOC_STROBE_ACT;
          col_n_d = cen_s2_q[0];
        end
        else if (single_bank_sequencing_i && !cen_s2_q[0])
        begin
          // Row ends early, column keeps data valid
          state_d = vsoc_pkg::VSOC_ST_EXTEND;
          col_n_d = `VSOC_STROBE_ACT;
        end
        else
          state_d = vsoc_pkg::VSOC_ST_IDLE;
      end
      vsoc_pkg::VSOC_ST_EXTEND:
      begin
        // Extension lasts exactly one clock
        state_d = vsoc_pkg::VSOC_ST_IDLE;
        col_n_d = `VSOC_STROBE_IDLE;
      end
      default:
        state_d = vsoc_pkg::VSOC_ST_IDLE;
    endcase
    // Transfer enable
    if (shift_load_i)
      xfer_d = `VSOC_STROBE_ACT;
    else if (write_d && state_d != vsoc_pkg::VSOC_ST_IDLE)
      xfer_d = `VSOC_STROBE_IDLE;
    else
      xfer_d = col_n_d;
  end

  always_ff @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q                  <= vsoc_pkg::VSOC_ST_IDLE;
      row_strobe_n_o           <= `VSOC_STROBE_IDLE;
      column_strobe_n_o        <= `VSOC_STROBE_IDLE;
      transfer_output_enable_o <= `VSOC_STROBE_IDLE;
    end
    else
    begin
      state_q                  <= state_d;
      row_strobe_n_o           <= row_n_d;
      column_strobe_n_o        <= col_n_d;
      transfer_output_enable_o <= xfer_d;
    end
  end

  // ----------------------------------------
  // Access kind
  // ----------------------------------------
  // Latched as the row opens, held to its end
  always_comb
  begin
    write_d = write_q;
    if (state_q == vsoc_pkg::VSOC_ST_IDLE && row_active_i)
      write_d = access_write_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      write_q <= 1'b0;
    end
    else
    begin
      write_q <= write_d;
    end
  end

  // ----------------------------------------
  // Mode capture
  // ----------------------------------------
  // Follows the synced pin while mode load lasts
  always_comb
  begin
    mode_d = mode_q;
    if (mode_load_i)
      mode_d = cen_s2_q[1];
  end

  always_ff @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mode_q <= `VSOC_MODE_BIT_RST;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  assign extra_mode_o = mode_q;

endmodule : vsoc_strobe_ctrl

// ===== vsoc_defines.svh
`ifndef VSOC_DEFINES_SVH
`define VSOC_DEFINES_SVH

// Mode bit value loaded at reset
`define VSOC_MODE_BIT_RST 1'b0
// Strobe levels
`define VSOC_STROBE_IDLE  1'b1
`define VSOC_STROBE_ACT   1'b0
// Synchroniser level while the pins are idle
`define VSOC_PIN_IDLE     2'h3

`endif

// ===== vsoc_pkg.sv
package vsoc_pkg;

  typedef enum logic [1:0] {
    VSOC_ACC_NONE,
    VSOC_ACC_READ,
    VSOC_ACC_WRITE,
    VSOC_ACC_SHIFT_LOAD
  } vsoc_acc_t;

  typedef enum logic [1:0] {
    VSOC_ST_IDLE,
    VSOC_ST_ROW,
    VSOC_ST_EXTEND
  } vsoc_state_t;

endpackage : vsoc_pkg

// ===== vsoc_strobe_monitor.sv
`timescale 1ns/1ps
module vsoc_strobe_monitor (
  input wire logic clock_i, nrst_i, row_active_i, access_write_i, shift_load_i,
  input wire logic single_bank_sequencing_i, mode_load_i, column_enable_in_n_i,
  input wire logic column_enable_in_zero_i, row_strobe_n_o, column_strobe_n_o,
  input wire logic transfer_output_enable_o, extra_mode_o
);
  wire r = row_strobe_n_o, k = column_strobe_n_o, x = transfer_output_enable_o;
  wire e = column_enable_in_n_i, s = shift_load_i, w = access_write_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  property p_ext; $rose(r) && $past(single_bank_sequencing_i) && !$past(e, 3) |-> !k; endproperty
  a_ext: assert property (p_ext) else $error("no extension");
  property p_end; !row_active_i && !r |=> r; endproperty
  a_end: assert property (p_end) else $error("row late");
  property p_off; $rose(r) |=> k; endproperty
  a_off: assert property (p_off) else $error("col stuck");
  property p_mode; (mode_load_i && column_enable_in_zero_i) [*5] |-> extra_mode_o; endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_sh; s [*2] |-> !x; endproperty
  a_sh: assert property (p_sh) else $error("shift");
  property p_wr; w && !s && !$past(s) |-> x; endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_rd; !w && !s && !$past(s) && !r |-> x == k; endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_pg; $rose(k) && !$past(w) && !$past(s) && !r |-> $rose(x); endproperty
  a_pg: assert property (p_pg) else $error("page");
endmodule : vsoc_strobe_monitor
bind vsoc_strobe_ctrl vsoc_strobe_monitor vsoc_strobe_monitor_i (.*);

// ===== vsoc_host_model.sv
`timescale 1ns/1ps
module vsoc_host_model (
  // Request side
  input  wire logic row_active_i, hold_i, gap_i,
  // Pin
  output logic      column_enable_in_n_o
);
  // Enable only within a request; hold drops before next row
  assign column_enable_in_n_o = !(row_active_i || hold_i) || gap_i;
endmodule : vsoc_host_model

// ===== test_vsoc_strobe_ctrl.sv
`timescale 1ns/1ps
module test_vsoc_strobe_ctrl;
  logic clock_i = 0, nrst_i = 0, row_active_i = 0, access_write_i = 0, shift_load_i = 0;
  logic single_bank_sequencing_i = 1, mode_load_i = 0, column_enable_in_zero_i = 0, hd = 0, gp = 0;
  logic column_enable_in_n_i, row_strobe_n_o, column_strobe_n_o, transfer_output_enable_o, extra_mode_o;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  wire x = transfer_output_enable_o;
  initial forever #10 clock_i = ~clock_i;
  vsoc_strobe_ctrl vsoc_strobe_ctrl_i (.*);
  vsoc_host_model vsoc_host_model_i (.row_active_i, .hold_i(hd), .gap_i(gp),
                                     .column_enable_in_n_o(column_enable_in_n_i));
  task st(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : st
  task chk(string s, logic e, logic v);
    tests_run++;
    if (v !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %b got %b", s, e, v);
    end
  endtask : chk
  task conclude();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task acc(string s, logic w, logic sb);
    access_write_i = w; single_bank_sequencing_i = sb; row_active_i = 1; hd = 1; st(6);
    chk("col", 0, column_strobe_n_o);
    chk("xfer", w, x);
    row_active_i = 0; st(1);
    chk("col ext", !sb, column_strobe_n_o);
    chk("xfer ext", w | !sb, x);
    chk("row off", 1, row_strobe_n_o);
    st(1);
    chk("col off", 1, column_strobe_n_o);
    hd = 0; st(4);
    $display("%s done", s);
  endtask : acc
  task t_page();
    access_write_i = 0; row_active_i = 1; st(6);
    gp = 1; st(4);
    chk("page hi", 1, x);
    chk("page col hi", 1, column_strobe_n_o);
    gp = 0; st(4);
    chk("page lo", 0, x);
    chk("page col lo", 0, column_strobe_n_o);
    row_active_i = 0; st(4);
    $display("page done");
  endtask : t_page
  task t_shift();
    shift_load_i = 1; st(3);
    chk("shift", 0, x);
    shift_load_i = 0; st(3);
    $display("shift done");
  endtask : t_shift
  task t_mode();
    mode_load_i = 1; column_enable_in_zero_i = 1; st(6);
    chk("mode on", 1, extra_mode_o);
    column_enable_in_zero_i = 0; st(6);
    chk("mode off", 0, extra_mode_o);
    mode_load_i = 0;
    $display("mode done");
  endtask : t_mode
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc > 400)
    begin
      error_cnt++;
      conclude();
    end
  end
  initial
  begin
    st(16); nrst_i = 1; st(4);
    acc("read", 0, 1); acc("write", 1, 1); acc("plain", 0, 0);
    t_page(); t_shift(); t_mode();
    conclude();
  end
endmodule : test_vsoc_strobe_ctrl
